// *** verilog/dif_decoder.sv ***
`timescale 1ns/1ps
module dif_decoder
  import dif_pkg::*;
#(
  parameter int unsigned N = NUM_TERM
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic [N-1:0]        i_term,
  input  wire logic                i_kp_we,
  input  wire logic [IDX_W-1:0]    i_kp_idx,
  input  wire logic [CODE_W-1:0]   i_kp_code,
  input  wire logic [1:0]          i_torque_mode_setting,
  input  wire logic [1:0]          i_pid_mode_setting,
  input  wire logic [1:0]          i_link_source_setting,
  input  wire logic                i_start_characteristic_setting,
  input  wire logic                i_volt_sense_reverse,
  input  wire logic                i_curr_sense_reverse,
  output logic                     o_kp_accept,
  output logic [N*CODE_W-1:0]      o_sel_codes,
  output logic                     o_keypad_write_permit,
  output logic                     o_pid_bypass_select,
  output logic                     o_pid_active,
  output logic                     o_freq_from_keypad,
  output logic                     o_analog_sense_invert,
  output logic                     o_volt_reverse_eff,
  output logic                     o_curr_reverse_eff,
  output logic                     o_power_loss_interlock,
  output logic                     o_torque_mode_bypass,
  output logic                     o_torque_ctrl_active,
  output logic [1:0]               o_volt_input_role,
  output logic                     o_link_command_gate,
  output logic                     o_link_freq_en,
  output logic                     o_link_run_en,
  output logic                     o_general_purpose_input,
  output logic                     o_pickup_start_gate,
  output logic                     o_pickup_start_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Returns {assigned, on} for a function code; several terminals on one code are ORed.
  function automatic logic [1:0] fn_match(input logic [N*CODE_W-1:0] codes,
                                          input logic [N-1:0] lvl,
                                          input logic [CODE_W-1:0] code);
    logic asg;
    logic act;
    asg = 1'b0;
    act = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (codes[i*CODE_W +: CODE_W] == code) begin
        asg = 1'b1;
        act = act | lvl[i];
      end
    end
    return {asg, act};
  endfunction

  // Setting values 1 and 2 both mean the mode is selected.
  function automatic logic fn_mode_on(input logic [1:0] s);
    return (s == MODE_ACTIVE_A) || (s == MODE_ACTIVE_B);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of each function; an unassigned code yields an off qualifier.
  // Codes 27 to 29 and 32 have no decode here at all.
  wire logic [1:0] m_kp   = fn_match(o_sel_codes, i_term, FC_KEYPAD_WRITE);
  wire logic [1:0] m_pid  = fn_match(o_sel_codes, i_term, FC_PID_BYPASS);
  wire logic [1:0] m_inv  = fn_match(o_sel_codes, i_term, FC_SENSE_INVERT);
  wire logic [1:0] m_pl   = fn_match(o_sel_codes, i_term, FC_POWER_LOSS);
  wire logic [1:0] m_trq  = fn_match(o_sel_codes, i_term, FC_TORQUE_BYPASS);
  wire logic [1:0] m_lnk  = fn_match(o_sel_codes, i_term, FC_LINK_GATE);
  wire logic [1:0] m_gpi  = fn_match(o_sel_codes, i_term, FC_GENERAL_INPUT);
  wire logic [1:0] m_stm  = fn_match(o_sel_codes, i_term, FC_PICKUP_GATE);
  wire logic       kp_nxt = m_kp[0];

  // Keypad writes pass when no terminal holds the permit code, or when it is on.
  // Reassigning the permit terminal therefore needs it on first.
  assign o_kp_accept = !m_kp[1] || m_kp[0];

  dif_sel_table u_table (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (i_kp_we && o_kp_accept),
    .i_idx   (i_kp_idx),
    .i_data  (i_kp_code),
    .o_codes (o_sel_codes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived drive qualifiers, computed from this cycle's inputs and registered below.
  wire logic torque_sel  = fn_mode_on(i_torque_mode_setting);
  wire logic pid_sel     = fn_mode_on(i_pid_mode_setting);
  wire logic trq_act_nxt = torque_sel && !m_trq[0];
  wire logic [1:0] role_nxt = trq_act_nxt ? ROLE_TORQUE_CMD :
                              (pid_sel ? ROLE_PID_FEEDBACK : ROLE_FREQ_CMD);

  // All qualifiers except o_kp_accept are flopped so downstream logic sees one consistent snapshot.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_keypad_write_permit   <= 1'b0;
      o_pid_bypass_select     <= 1'b0;
      o_pid_active            <= 1'b0;
      o_freq_from_keypad      <= 1'b0;
      o_analog_sense_invert   <= 1'b0;
      o_volt_reverse_eff      <= 1'b0;
      o_curr_reverse_eff      <= 1'b0;
      o_power_loss_interlock  <= 1'b0;
      o_torque_mode_bypass    <= 1'b0;
      o_torque_ctrl_active    <= 1'b0;
      o_volt_input_role       <= ROLE_FREQ_CMD;
      o_link_command_gate     <= 1'b0;
      o_link_freq_en          <= 1'b0;
      o_link_run_en           <= 1'b0;
      o_general_purpose_input <= 1'b0;
      o_pickup_start_gate     <= 1'b0;
      o_pickup_start_en       <= 1'b0;
    end else begin
      o_keypad_write_permit   <= kp_nxt;
      o_pid_bypass_select     <= m_pid[0];
      o_pid_active            <= pid_sel && !m_pid[0];
      o_freq_from_keypad      <= m_pid[0];
      o_analog_sense_invert   <= m_inv[0];
      o_volt_reverse_eff      <= i_volt_sense_reverse ^ m_inv[0];
      o_curr_reverse_eff      <= i_curr_sense_reverse ^ m_inv[0];
      o_power_loss_interlock  <= m_pl[0];
      o_torque_mode_bypass    <= m_trq[0];
      o_torque_ctrl_active    <= trq_act_nxt;
      o_volt_input_role       <= role_nxt;
      o_link_command_gate     <= m_lnk[0];
      o_link_freq_en          <= m_lnk[0] && i_link_source_setting[LINK_FREQ_BIT];
      o_link_run_en           <= m_lnk[0] && i_link_source_setting[LINK_RUN_BIT];
      o_general_purpose_input <= m_gpi[0];
      o_pickup_start_gate     <= m_stm[0];
      o_pickup_start_en       <= m_stm[0] && i_start_characteristic_setting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks tied to the decode above.
  a_kp_write_block: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_kp_we && !o_kp_accept) |=> (o_sel_codes == $past(o_sel_codes)))
    else $error("Keypad write changed the table while blocked.");

  a_kp_write_take: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_kp_we && o_kp_accept && (i_kp_idx < 4'(N))) |=>
      (o_sel_codes[$past(i_kp_idx)*CODE_W +: CODE_W] == $past(i_kp_code)))
    else $error("Accepted keypad write did not land.");

  a_pid_bypass_out: assert property (@(posedge i_clk) disable iff (i_rst)
    o_freq_from_keypad |-> !o_pid_active)
    else $error("Pid active while bypassed.");

  a_sense_invert: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 (o_volt_reverse_eff == ($past(i_volt_sense_reverse) ^ o_analog_sense_invert)))
    else $error("Voltage sense inversion wrong.");

  a_power_loss: assert property (@(posedge i_clk) disable iff (i_rst)
    (!m_pl[1]) |=> !o_power_loss_interlock)
    else $error("Power loss flagged with no terminal assigned.");

  a_torque_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    !fn_mode_on(i_torque_mode_setting) |=> !o_torque_ctrl_active)
    else $error("Torque control active outside modes 1 and 2.");

  a_volt_role: assert property (@(posedge i_clk) disable iff (i_rst)
    o_torque_ctrl_active == (o_volt_input_role == ROLE_TORQUE_CMD))
    else $error("Voltage input role mismatches torque state.");

  a_link_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_link_command_gate |-> !(o_link_freq_en || o_link_run_en))
    else $error("Link command passed with gate off.");

  a_pickup_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    (m_stm[1] && !m_stm[0]) |=> !o_pickup_start_en)
    else $error("Pick-up start enabled with gate input off.");

  a_gpi_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_general_purpose_input) |-> $past(m_gpi[1]))
    else $error("General input rose with no terminal assigned.");

endmodule

// *** pkg/dif_pkg.sv ***
package dif_pkg;

  // Terminal count and function-code width.
  localparam int unsigned NUM_TERM  = 9;
  localparam int unsigned CODE_W    = 6;
  localparam int unsigned IDX_W     = 4;

  // Input function codes decoded by this block.
  localparam logic [5:0] FC_KEYPAD_WRITE   = 6'h13;
  localparam logic [5:0] FC_PID_BYPASS     = 6'h14;
  localparam logic [5:0] FC_SENSE_INVERT   = 6'h15;
  localparam logic [5:0] FC_POWER_LOSS     = 6'h16;
  localparam logic [5:0] FC_TORQUE_BYPASS  = 6'h17;
  localparam logic [5:0] FC_LINK_GATE      = 6'h18;
  localparam logic [5:0] FC_GENERAL_INPUT  = 6'h19;
  localparam logic [5:0] FC_PICKUP_GATE    = 6'h1A;

  // Torque mode and pid mode setting values that count as active.
  localparam logic [1:0] MODE_ACTIVE_A     = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_B     = 2'h2;

  // Link source setting field positions.
  localparam int unsigned LINK_FREQ_BIT    = 0;
  localparam int unsigned LINK_RUN_BIT     = 1;

  // Role of the voltage analog input.
  localparam logic [1:0] ROLE_FREQ_CMD     = 2'h0;
  localparam logic [1:0] ROLE_TORQUE_CMD   = 2'h1;
  localparam logic [1:0] ROLE_PID_FEEDBACK = 2'h2;

  // Reset assignment of terminals one to nine: codes 0 to 8, terminal one in the low field.
  localparam logic [NUM_TERM*CODE_W-1:0] SEL_RESET = 54'h8_1C61_440C_2040;

endpackage

// *** verilog/dif_sel_table.sv ***
`timescale 1ns/1ps
module dif_sel_table
  import dif_pkg::*;
#(
  parameter int unsigned           N     = NUM_TERM,
  parameter int unsigned           W     = CODE_W,
  parameter logic [N*W-1:0]        RESET = SEL_RESET
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_we,
  input  wire logic [IDX_W-1:0]    i_idx,
  input  wire logic [W-1:0]        i_data,
  output logic      [N*W-1:0]      o_codes
);

  ////////////////////////////////////////////////////////////////////////////
  // One selection word per terminal; an index past the last terminal is dropped.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_codes <= RESET;
    end else if (i_we && (32'(i_idx) < N)) begin
      o_codes[i_idx*W +: W] <= i_data;
    end
  end

endmodule

// *** verif/dif_switch_bank.sv ***
`timescale 1ns/1ps
// Switches between each terminal and the input common; a closed contact reads as on.
module dif_switch_bank (
  input  wire logic [8:0] i_closed,
  output logic      [8:0] o_term
);
  // Contacts are ideal and bounce free, so no settling time is modelled.
  assign o_term = i_closed;
endmodule

// *** verif/dif_decoder_tb.sv ***
`timescale 1ns/1ps
module dif_decoder_tb;
  import dif_pkg::*;
  typedef struct {int due; bit sel; logic [53:0] v;} dif_note_s;
  logic        i_clk = 0, i_rst = 1, we = 0, ss = 0, vs = 0, cs = 0;
  logic [8:0]  sw = '0, term;
  logic [3:0]  idx = '0;
  logic [5:0]  code = '0;
  logic [1:0]  tm = '0, pm = '0, ls = '0, role;
  logic [53:0] sel_m = SEL_RESET, sel_o;
  logic        kpa, kpp, pbs, pa, fk, asi, vr, cr, pli, tmb, tca, lcg, lf, lr, gpi, psg, pse;
  logic [18:0] q_o;
  dif_note_s   notes[$], n;
  int          cyc = 0, n_mismatch = 0, compares = 0, x;
  // Option-card codes that must decode to nothing.
  logic [5:0]  opt_codes [4] = '{6'd27, 6'd28, 6'd29, 6'd32};
  //////////////////////////////////////////////////////////////////////////
  // The switch bank stands in for the operator wiring.
  dif_switch_bank u_sw (.i_closed(sw), .o_term(term));
  dif_decoder DUT (.i_clk(i_clk), .i_rst(i_rst), .i_term(term), .i_kp_we(we), .i_kp_idx(idx),
    .i_kp_code(code), .i_torque_mode_setting(tm), .i_pid_mode_setting(pm), .i_link_source_setting(ls),
    .i_start_characteristic_setting(ss), .i_volt_sense_reverse(vs), .i_curr_sense_reverse(cs),
    .o_kp_accept(kpa), .o_sel_codes(sel_o), .o_keypad_write_permit(kpp), .o_pid_bypass_select(pbs),
    .o_pid_active(pa), .o_freq_from_keypad(fk), .o_analog_sense_invert(asi), .o_volt_reverse_eff(vr),
    .o_curr_reverse_eff(cr), .o_power_loss_interlock(pli), .o_torque_mode_bypass(tmb),
    .o_torque_ctrl_active(tca), .o_volt_input_role(role), .o_link_command_gate(lcg),
    .o_link_freq_en(lf), .o_link_run_en(lr), .o_general_purpose_input(gpi),
    .o_pickup_start_gate(psg), .o_pickup_start_en(pse));
  // All qualifier outputs packed in one word so one compare covers them.
  assign q_o = {kpa, kpp, pbs, pa, fk, asi, vr, cr, pli, tmb, tca, role, lcg, lf, lr, gpi, psg, pse};
  always #50 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////////
  // Terminals holding code c, ORed; the table model decides who holds what.
  function automatic logic q(logic [8:0] t, logic [5:0] c);
    q = 0;
    for (int i = 0; i < 9; i++) q |= t[i] & (sel_m[i*6+:6] === c);
  endfunction
  function automatic logic act(logic [1:0] m);
    return m == MODE_ACTIVE_A || m == MODE_ACTIVE_B;
  endfunction
  // Expected qualifiers for levels t under the present settings.
  function automatic logic [18:0] expv(logic [8:0] t);
    logic [26:19] f;
    logic ta;
    for (int c = 19; c <= 26; c++) f[c] = q(t, 6'(c));
    ta = act(tm) & ~f[23];
    return {~q('1, FC_KEYPAD_WRITE) | f[19], f[19], f[20], act(pm) & ~f[20], f[20], f[21], vs ^ f[21],
      cs ^ f[21], f[22], f[23], ta, ta ? ROLE_TORQUE_CMD : act(pm) ? ROLE_PID_FEEDBACK : ROLE_FREQ_CMD,
      f[24], f[24] & ls[LINK_FREQ_BIT], f[24] & ls[LINK_RUN_BIT], f[25], f[26], f[26] & ss};
  endfunction
  task automatic chk(string nm, logic [53:0] e, logic [53:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Drive levels at the falling edge and note the result due one edge later.
  task automatic drv(logic [8:0] t);
    @(negedge i_clk);
    sw = t;
    notes.push_back('{cyc + 1, 1'b0, 54'(expv(t))});
  endtask
  // A keypad write; the bench decides acceptance from the levels it holds.
  task automatic wr(logic [3:0] i, logic [5:0] c);
    @(negedge i_clk);
    if (i < 9 && (~q('1, FC_KEYPAD_WRITE) | q(sw, FC_KEYPAD_WRITE))) sel_m[i*6+:6] = c;
    we = 1;
    idx = i;
    code = c;
    notes.push_back('{cyc + 1, 1'b1, sel_m});
    @(negedge i_clk);
    we = 0;
    @(negedge i_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Watcher: settled outputs are read shortly after each rising edge.
  always begin
    @(posedge i_clk);
    cyc++;
    #10;
    if (cyc > 1000) begin
      n_mismatch++;
      end_of_test();
    end else begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
        n = notes.pop_front();
        if (n.sel) chk("sel_codes", n.v, sel_o);
        else chk("qualifiers", n.v, {35'h0, q_o});
      end
    end
  end
  // Main sequence.
  initial begin
    x = $urandom(32'h36c5);
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 0;
    // Terminal i holds code i out of reset, checked against the index itself.
    for (int i = 0; i < 9; i++) chk("reset_code", 54'(i), 54'(sel_o[i*6+:6]));
    notes.push_back('{cyc + 1, 1'b1, sel_m});
    drv('0);
    $display("test reset done");
    foreach (opt_codes[j]) begin
      wr(8, opt_codes[j]);
      drv(9'h100);
    end
    for (int k = 7; k >= 0; k--) wr(4'(k), 6'(FC_KEYPAD_WRITE + k));
    drv('0);
    $display("test assign done");
    // Settings move a whole cycle before the levels, so the previous note sees stable settings.
    repeat (40) begin
      x = $urandom;
      @(negedge i_clk);
      {tm, pm, ls, ss, vs, cs} = x[8:0];
      drv(9'($urandom));
    end
    $display("test random done");
    drv('0);
    wr(8, FC_GENERAL_INPUT);
    drv(9'h001);
    wr(9, 6'h00);
    wr(8, FC_GENERAL_INPUT);
    drv(9'h100);
    drv(9'h001);
    wr(0, 6'h00);
    drv('0);
    wr(1, FC_GENERAL_INPUT);
    drv(9'h002);
    repeat (3) @(posedge i_clk);
    $display("test permit done");
    end_of_test();
  end
endmodule
